// ### dscm_pkg.sv
// Package: register map, field layouts and fault codes for the serial command map
package dscm_pkg;
    localparam logic [15:0] ADDR_DRIVE_CONTROL = 16'h2000;
    localparam logic [15:0] ADDR_FREQ_SETPOINT = 16'h2001;
    localparam logic [15:0] ADDR_FAULT_RESET = 16'h2002;
    localparam logic [15:0] ADDR_FAULT_CODE = 16'h2100;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int CTL_RUN_LSB = 0;
    localparam int CTL_DIR_LSB = 4;
    localparam int CTL_RAMP_LSB = 6;
    localparam int FR_EXT_FAULT_BIT = 0;
    localparam int FR_CLEAR_BIT = 1;
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_STOP = 2'h1;
    localparam logic [1:0] CMD_RUN = 2'h2;
    localparam logic [1:0] CMD_JOG_RUN = 2'h3;
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_REV = 2'h2;
    localparam logic [1:0] DIR_TOGGLE = 2'h3;
    localparam logic [1:0] RAMP_SET_ONE = 2'h0;
    localparam logic [1:0] RAMP_SET_TWO = 2'h1;
    localparam int NUM_FAULTS = 27;
    localparam logic [15:0] FC_NONE = 16'h0000;
    localparam logic [15:0] FC_OVERCURRENT = 16'h0001;
    localparam logic [15:0] FC_OVERVOLTAGE = 16'h0002;
    localparam logic [15:0] FC_SWITCH_OVERHEAT = 16'h0003;
    localparam logic [15:0] FC_DRIVE_OVERLOAD = 16'h0005;
    localparam logic [15:0] FC_OVERLOAD_ONE = 16'h0006;
    localparam logic [15:0] FC_OVERLOAD_TWO = 16'h0007;
    localparam logic [15:0] FC_EXTERNAL = 16'h0008;
    localparam logic [15:0] FC_ACCEL_OC = 16'h0009;
    localparam logic [15:0] FC_DECEL_OC = 16'h000A;
    localparam logic [15:0] FC_STEADY_OC = 16'h000B;
    localparam logic [15:0] FC_GROUND = 16'h000C;
    localparam logic [15:0] FC_PHASE_LOSS = 16'h000E;
    localparam logic [15:0] FC_AUTO_RAMP = 16'h0010;
    localparam logic [15:0] FC_SW_PROTECT = 16'h0011;
    localparam logic [15:0] FC_PS_WRITE = 16'h0012;
    localparam logic [15:0] FC_PS_READ = 16'h0013;
    localparam logic [15:0] FC_HPF_COMBINED = 16'h0014;
    localparam logic [15:0] FC_HPF_OVERVOLT = 16'h0015;
    localparam logic [15:0] FC_HPF_GROUND = 16'h0016;
    localparam logic [15:0] FC_HPF_OVERCURRENT = 16'h0017;
    localparam logic [15:0] FC_U_PHASE = 16'h0018;
    localparam logic [15:0] FC_V_PHASE = 16'h0019;
    localparam logic [15:0] FC_W_PHASE = 16'h001A;
    localparam logic [15:0] FC_DC_BUS = 16'h001B;

    typedef struct packed {
        logic req;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dscm_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } dscm_rsp_s;

    typedef struct packed {
        logic run;
        logic jog;
        logic reverse;
        logic ramp_set_two;
    } dscm_drive_s;
endpackage

// ### dscm_fault_encoder.sv
// Fault encoder: priority-encodes raw fault sources into a fault code
module dscm_fault_encoder (
    input wire logic [26:0] fault_src,
    output logic [15:0] fault_code
);
    // Bit i of fault_src maps to table entry i; lowest index wins
    function automatic logic [15:0] code_of(input logic [4:0] idx);
        logic [15:0] c;
        c = dscm_pkg::FC_NONE;
        case (idx)
            5'd0: c = dscm_pkg::FC_OVERCURRENT; // [R10]
            5'd1: c = dscm_pkg::FC_OVERVOLTAGE; // [R10]
            5'd2: c = dscm_pkg::FC_SWITCH_OVERHEAT; // [R10]
            5'd3: c = dscm_pkg::FC_DRIVE_OVERLOAD; // [R11]
            5'd4: c = dscm_pkg::FC_OVERLOAD_ONE; // [R11]
            5'd5: c = dscm_pkg::FC_OVERLOAD_TWO; // [R11]
            5'd6: c = dscm_pkg::FC_EXTERNAL; // [R11]
            5'd7: c = dscm_pkg::FC_ACCEL_OC; // [R12]
            5'd8: c = dscm_pkg::FC_DECEL_OC; // [R12]
            5'd9: c = dscm_pkg::FC_STEADY_OC; // [R12]
            5'd10: c = dscm_pkg::FC_GROUND; // [R13]
            5'd11: c = dscm_pkg::FC_PHASE_LOSS; // [R13]
            5'd12: c = dscm_pkg::FC_AUTO_RAMP; // [R14]
            5'd13: c = dscm_pkg::FC_SW_PROTECT; // [R14]
            5'd14: c = dscm_pkg::FC_PS_WRITE; // [R15]
            5'd15: c = dscm_pkg::FC_PS_READ; // [R15]
            5'd16: c = dscm_pkg::FC_HPF_COMBINED; // [R16]
            5'd17: c = dscm_pkg::FC_HPF_OVERVOLT; // [R16]
            5'd18: c = dscm_pkg::FC_HPF_GROUND; // [R16]
            5'd19: c = dscm_pkg::FC_HPF_OVERCURRENT; // [R16]
            5'd20: c = dscm_pkg::FC_U_PHASE; // [R17]
            5'd21: c = dscm_pkg::FC_V_PHASE; // [R17]
            5'd22: c = dscm_pkg::FC_W_PHASE; // [R17]
            5'd23: c = dscm_pkg::FC_DC_BUS; // [R17]
            default: c = dscm_pkg::FC_NONE; // [R18]
        endcase
        return c;
    endfunction

    always_comb begin
        fault_code = dscm_pkg::FC_NONE; // [R9]
        for (int i = dscm_pkg::NUM_FAULTS - 4; i >= 0; i--) begin
            if (fault_src[i]) begin
                fault_code = code_of(5'(i));
            end
        end
    end
endmodule

// ### dscm_command_map.sv
// Top: serial command/status register map of the motor drive
// What this block does
// R1 - Parameter address: high byte is group, low byte is number within group.
// R2 - A parameter read command requests exactly one parameter.
// R3 - Control bits 1:0: none, stop, run, jog plus run.
// R4 - Control bits 5:4: none, forward, reverse, toggle present direction.
// R5 - Control bits 7:6 select first or second ramp time set.
// R6 - Fault/reset bit 0 set raises the external fault.
// R7 - Fault/reset bit 1 clears latched fault; reserved bits ignored.
// R8 - Setpoint write updates commanded frequency for serial frequency source.
// R9 - Fault code reads zero when no fault occurred.
// R10 - Codes 1-3: over-current, over-voltage, switch overheat.
// R11 - Codes 5-8: overload, overload one, overload two, external fault.
// R12 - Codes 9-11: twice rated current in accel, decel, steady run.
// R13 - Code 12 ground fault, code 14 input phase loss.
// R14 - Code 16 auto ramp failure, code 17 software protection.
// R15 - Code 18 power stage write failure, 19 read failure.
// R16 - Codes 20-23: hardware protection failures.
// R17 - Codes 24-26 phase errors, 27 DC bus error.
// R18 - Codes 4, 13 and 15 are never reported.
module dscm_command_map (
    input wire logic clk,
    input wire logic rst,
    input wire dscm_pkg::dscm_req_s bus_req,
    input wire logic [26:0] fault_in,
    output dscm_pkg::dscm_rsp_s bus_rsp,
    output dscm_pkg::dscm_drive_s drive_cmd,
    output logic [15:0] freq_setpoint,
    output logic freq_update,
    output logic stop_pulse,
    output logic [7:0] param_group,
    output logic [7:0] param_number,
    output logic param_write,
    output logic param_read,
    output logic [15:0] param_wdata,
    output logic [15:0] fault_code,
    output logic fault_active
);
    logic [26:0] fault_sync1_ff;
    logic [26:0] fault_sync2_ff;
    logic [26:0] fault_latch_ff;
    logic ext_fault_ff;
    logic [15:0] code_now;
    logic [26:0] nxt_latch;
    logic is_ctl;
    logic is_freq;
    logic is_fr;
    logic is_code;
    logic is_param;
    logic wr_ctl;
    logic wr_fr;
    logic clear_req;

    // Decode: an address with high byte below 20h is a parameter address; other non-fixed addresses are unmapped
    always_comb begin
        is_ctl = 1'b0;
        is_freq = 1'b0;
        is_fr = 1'b0;
        is_code = 1'b0;
        is_param = 1'b0;
        if (bus_req.addr == dscm_pkg::ADDR_DRIVE_CONTROL) begin
            is_ctl = 1'b1;
        end else if (bus_req.addr == dscm_pkg::ADDR_FREQ_SETPOINT) begin
            is_freq = 1'b1;
        end else if (bus_req.addr == dscm_pkg::ADDR_FAULT_RESET) begin
            is_fr = 1'b1;
        end else if (bus_req.addr == dscm_pkg::ADDR_FAULT_CODE) begin
            is_code = 1'b1;
        end else if (bus_req.addr[15:8] < 8'h20) begin
            is_param = 1'b1;
        end
    end

    assign wr_ctl = bus_req.req && bus_req.write && is_ctl;
    assign wr_fr = bus_req.req && bus_req.write && is_fr;
    assign clear_req = wr_fr && bus_req.wdata[dscm_pkg::FR_CLEAR_BIT]; // [R7]

    // Fault inputs cross from outside logic through two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_sync1_ff <= '0;
            fault_sync2_ff <= '0;
        end else begin
            fault_sync1_ff <= fault_in;
            fault_sync2_ff <= fault_sync1_ff;
        end
    end

    // External fault from serial write; clear loses to a new set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_fault_ff <= 1'b0;
        end else if (wr_fr && bus_req.wdata[dscm_pkg::FR_EXT_FAULT_BIT]) begin
            ext_fault_ff <= 1'b1; // [R6]
        end else if (clear_req) begin
            ext_fault_ff <= 1'b0; // [R7]
        end
    end

    // Sticky fault latch; a present source survives a clear
    always_comb begin
        nxt_latch = fault_latch_ff | fault_sync2_ff;
        nxt_latch[6] = nxt_latch[6] | ext_fault_ff; // [R6]
        if (clear_req) begin
            nxt_latch = fault_sync2_ff; // [R7]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_latch_ff <= '0;
        end else begin
            fault_latch_ff <= nxt_latch;
        end
    end

    dscm_fault_encoder u_enc (
        .fault_src(fault_latch_ff),
        .fault_code(code_now)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_code <= dscm_pkg::FC_NONE; // [R9]
            fault_active <= 1'b0;
        end else begin
            fault_code <= code_now;
            fault_active <= (code_now != dscm_pkg::FC_NONE);
        end
    end

    // Run, direction and ramp set from control word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_cmd <= '0;
            stop_pulse <= 1'b0;
        end else begin
            stop_pulse <= 1'b0;
            if (wr_ctl) begin
                case (bus_req.wdata[dscm_pkg::CTL_RUN_LSB +: 2])
                    dscm_pkg::CMD_STOP: begin
                        drive_cmd.run <= 1'b0; // [R3]
                        drive_cmd.jog <= 1'b0;
                        stop_pulse <= 1'b1;
                    end
                    dscm_pkg::CMD_RUN: begin
                        drive_cmd.run <= 1'b1; // [R3]
                        drive_cmd.jog <= 1'b0;
                    end
                    dscm_pkg::CMD_JOG_RUN: begin
                        drive_cmd.run <= 1'b1; // [R3]
                        drive_cmd.jog <= 1'b1;
                    end
                    default: begin
                    end
                endcase
                case (bus_req.wdata[dscm_pkg::CTL_DIR_LSB +: 2])
                    dscm_pkg::DIR_FWD: drive_cmd.reverse <= 1'b0; // [R4]
                    dscm_pkg::DIR_REV: drive_cmd.reverse <= 1'b1; // [R4]
                    dscm_pkg::DIR_TOGGLE: drive_cmd.reverse <= ~drive_cmd.reverse; // [R4]
                    default: begin
                    end
                endcase
                case (bus_req.wdata[dscm_pkg::CTL_RAMP_LSB +: 2])
                    dscm_pkg::RAMP_SET_ONE: drive_cmd.ramp_set_two <= 1'b0; // [R5]
                    dscm_pkg::RAMP_SET_TWO: drive_cmd.ramp_set_two <= 1'b1; // [R5]
                    default: begin
                    end
                endcase
            end
        end
    end

    // Frequency setpoint
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_setpoint <= dscm_pkg::RESET_WORD;
            freq_update <= 1'b0;
        end else begin
            freq_update <= bus_req.req && bus_req.write && is_freq;
            if (bus_req.req && bus_req.write && is_freq) begin
                freq_setpoint <= bus_req.wdata; // [R8]
            end
        end
    end

    // Parameter access forwarded by group and number
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            param_group <= 8'h00;
            param_number <= 8'h00;
            param_write <= 1'b0;
            param_read <= 1'b0;
            param_wdata <= dscm_pkg::RESET_WORD;
        end else begin
            param_write <= bus_req.req && bus_req.write && is_param;
            param_read <= bus_req.req && !bus_req.write && is_param; // [R2]
            if (bus_req.req && is_param) begin
                param_group <= bus_req.addr[15:8]; // [R1]
                param_number <= bus_req.addr[7:0]; // [R1]
                param_wdata <= bus_req.wdata;
            end
        end
    end

    // Response: one cycle after request; wrong direction or unmapped flags err
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.ack <= bus_req.req;
            bus_rsp.rdata <= dscm_pkg::RESET_WORD;
            bus_rsp.err <= 1'b0;
            if (bus_req.req) begin
                if (is_code && !bus_req.write) begin
                    bus_rsp.rdata <= code_now;
                end else if ((is_ctl || is_freq || is_fr) && bus_req.write) begin
                    bus_rsp.err <= 1'b0;
                end else if (is_param) begin
                    bus_rsp.err <= 1'b0;
                end else begin
                    bus_rsp.err <= 1'b1;
                end
            end
        end
    end
endmodule

// ### dscm_master_model.sv
// Serial bus master model issuing single word register accesses
module dscm_master_model (
    input wire logic clk,
    input wire dscm_pkg::dscm_rsp_s bus_rsp,
    output dscm_pkg::dscm_req_s bus_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic timed_out;
    initial begin
        bus_req = '0;
        timed_out = 1'b0;
    end
    // One word per request, so a parameter read asks for one parameter
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                          output dscm_pkg::dscm_rsp_s rsp);
        int i;
        @(posedge clk);
        #1;
        bus_req = {1'b1, wr, a, d};
        @(posedge clk);
        #1;
        bus_req = {1'b0, ~wr, ~a, ~d};
        for (i = 0; i < 4 && bus_rsp.ack !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        rsp = bus_rsp;
        timed_out = (bus_rsp.ack !== 1'b1);
    endtask
endmodule

// ### dscm_command_map_asserts.sv
// Checker: port level properties of the command map
module dscm_command_map_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire dscm_pkg::dscm_req_s bus_req,
    input wire logic [26:0] fault_in,
    input wire dscm_pkg::dscm_rsp_s bus_rsp,
    input wire dscm_pkg::dscm_drive_s drive_cmd,
    input wire logic [15:0] freq_setpoint,
    input wire logic stop_pulse,
    input wire logic [7:0] param_group,
    input wire logic [7:0] param_number,
    input wire logic [15:0] fault_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_ctl;
    logic wr_flt;
    logic par;
    assign wr_ctl = bus_req.req && bus_req.write && bus_req.addr == dscm_pkg::ADDR_DRIVE_CONTROL;
    assign wr_flt = bus_req.req && bus_req.write && bus_req.addr == dscm_pkg::ADDR_FAULT_RESET;
    assign par = bus_req.req && bus_req.addr[15:8] < 8'h20;
    run_cmd_a: assert property (wr_ctl && bus_req.wdata[1] |=> drive_cmd.run)
        else $error("run not set");
    stop_cmd_a: assert property (wr_ctl && bus_req.wdata[1:0] == 2'h1
        |=> stop_pulse && !drive_cmd.run) else $error("stop not applied");
    dir_set_a: assert property (wr_ctl && bus_req.wdata[5:4] inside {2'h1, 2'h2}
        |=> drive_cmd.reverse == $past(bus_req.wdata[5])) else $error("dir wrong");
    dir_toggle_a: assert property (wr_ctl && bus_req.wdata[5:4] == 2'h3
        |=> drive_cmd.reverse != $past(drive_cmd.reverse)) else $error("no toggle");
    ramp_sel_a: assert property (wr_ctl && !bus_req.wdata[7]
        |=> drive_cmd.ramp_set_two == $past(bus_req.wdata[6])) else $error("ramp");
    param_addr_a: assert property (par |=> param_group == $past(bus_req.addr[15:8])
        && param_number == $past(bus_req.addr[7:0])) else $error("param addr");
    ack_once_a: assert property (bus_req.req |=> bus_rsp.ack) else $error("no ack");
    freq_set_a: assert property (bus_req.req && bus_req.write
        && bus_req.addr == dscm_pkg::ADDR_FREQ_SETPOINT
        |=> freq_setpoint == $past(bus_req.wdata)) else $error("setpoint not taken");
    ext_fault_a: assert property (wr_flt && bus_req.wdata[0] && fault_in[5:0] == 6'h00
        |-> ##[1:6] fault_code == dscm_pkg::FC_EXTERNAL) else $error("ext fault");
    fault_clear_a: assert property ((fault_in == 27'h0) [*6]
        ##0 (wr_flt && bus_req.wdata[1:0] == 2'h2)
        |-> ##[1:6] fault_code == 16'h0000) else $error("not cleared");
    code_legal_a: assert property (!(fault_code inside {16'h0004, 16'h000D, 16'h000F})
        && fault_code <= 16'h001B) else $error("illegal code");
endmodule
bind dscm_command_map dscm_command_map_asserts chk_u (.clk(clk), .rst(rst),
    .bus_req(bus_req), .fault_in(fault_in), .bus_rsp(bus_rsp), .drive_cmd(drive_cmd),
    .freq_setpoint(freq_setpoint), .stop_pulse(stop_pulse), .param_group(param_group),
    .param_number(param_number), .fault_code(fault_code));

// ### tb_drive_serial_command_status_map.sv
// Testbench: random and corner register traffic against the command map
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_drive_serial_command_status_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [26:0] fault_in = '0;
    dscm_pkg::dscm_req_s bus_req;
    dscm_pkg::dscm_rsp_s bus_rsp, rsp;
    dscm_pkg::dscm_drive_s drive_cmd;
    logic [15:0] freq_setpoint, param_wdata, fault_code, w, a;
    logic [7:0] param_group, param_number;
    logic freq_update, stop_pulse, param_write, param_read, fault_active, e_run, e_rev, e_jog;
    int n_errors = 0;
    int checks_done = 0;
    int i;
    logic [15:0] codes [24] = '{16'h1, 16'h2, 16'h3, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'hA,
        16'hB, 16'hC, 16'hE, 16'h10, 16'h11, 16'h12, 16'h13, 16'h14, 16'h15, 16'h16, 16'h17,
        16'h18, 16'h19, 16'h1A, 16'h1B};
    always #4 clk = ~clk;
    dscm_master_model m_u (.clk(clk), .bus_rsp(bus_rsp), .bus_req(bus_req));
    dscm_command_map dut_u (.clk(clk), .rst(rst), .bus_req(bus_req), .fault_in(fault_in),
        .bus_rsp(bus_rsp), .drive_cmd(drive_cmd), .freq_setpoint(freq_setpoint),
        .freq_update(freq_update), .stop_pulse(stop_pulse), .param_group(param_group),
        .param_number(param_number), .param_write(param_write), .param_read(param_read),
        .param_wdata(param_wdata), .fault_code(fault_code), .fault_active(fault_active));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [15:0] ad, input logic [15:0] d);
        m_u.access(wr, ad, d, rsp);
        if (m_u.timed_out) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic wait_code(input logic [15:0] e);
        int k;
        for (k = 0; k < 30 && fault_code !== e; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK(fault_code, e)
        if (fault_code !== e) finish_test();
    endtask
    initial begin
        i = $urandom(42215);
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        `CHK(fault_code, 16'h0000)
        e_run = 1'b0;
        e_rev = 1'b0;
        e_jog = 1'b0;
        for (i = 0; i < 16; i++) begin
            w = $urandom;
            w = {w[15:8], 1'b0, w[6], i[3:2], w[3:2], i[1:0]};
            if (w[1:0] != 2'h0) e_run = w[1];
            if (w[1:0] != 2'h0) e_jog = (w[1:0] == 2'h3);
            if (w[5:4] == 2'h3) e_rev = ~e_rev;
            else if (w[5:4] != 2'h0) e_rev = w[5];
            acc(1'b1, dscm_pkg::ADDR_DRIVE_CONTROL, w);
            `CHK(drive_cmd.run, e_run)
            `CHK(drive_cmd.reverse, e_rev)
            `CHK(drive_cmd.ramp_set_two, w[6])
            `CHK(drive_cmd.jog, e_jog)
            `CHK(stop_pulse, w[1:0] == 2'h1)
        end
        $display("control word test done");
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        `CHK(drive_cmd, 4'h0)
        `CHK(freq_setpoint, 16'h0000)
        `CHK(fault_code, 16'h0000)
        $display("mid-run reset test done");
        for (i = 0; i < 4; i++) begin
            w = $urandom;
            a = {3'h0, 13'($urandom)};
            acc(1'b1, dscm_pkg::ADDR_FREQ_SETPOINT, w);
            `CHK(freq_setpoint, w)
            `CHK(freq_update, 1'b1)
            acc(1'b1, a, w);
            `CHK({param_group, param_number, param_wdata}, {a, w})
            `CHK(param_write, 1'b1)
            acc(1'b0, a, 16'h0000);
            `CHK(rsp.err, 1'b0)
            `CHK(param_read, 1'b1)
        end
        acc(1'b0, 16'h2003, 16'h0000);
        `CHK(rsp.err, 1'b1)
        $display("setpoint and parameter test done");
        for (i = 0; i < 24; i++) begin
            #0 fault_in = 27'h1 << i;
            wait_code(codes[i]);
            `CHK(fault_active, 1'b1)
            acc(1'b0, dscm_pkg::ADDR_FAULT_CODE, 16'h0000);
            `CHK(rsp.rdata, codes[i])
            fault_in = '0;
            repeat (8) @(posedge clk);
            acc(1'b1, dscm_pkg::ADDR_FAULT_RESET, 16'h0002);
            wait_code(16'h0000);
            `CHK(fault_active, 1'b0)
        end
        acc(1'b1, dscm_pkg::ADDR_FAULT_RESET, 16'h0001);
        wait_code(dscm_pkg::FC_EXTERNAL);
        acc(1'b1, dscm_pkg::ADDR_FAULT_RESET, 16'h0002);
        wait_code(16'h0000);
        acc(1'b1, dscm_pkg::ADDR_FAULT_RESET, 16'h0003);
        wait_code(dscm_pkg::FC_EXTERNAL);
        acc(1'b1, dscm_pkg::ADDR_FAULT_RESET, 16'h0002);
        wait_code(16'h0000);
        $display("fault code test done");
        finish_test();
    end
endmodule
